//--- omc_pkg.sv
// Shared constants for the optical module control and status link
package omc_pkg;
  localparam int CLK_MHZ = 200;
  localparam int T_RESET_US = 10;
  localparam int T_RESET_CYC = T_RESET_US * CLK_MHZ;
  localparam int T_BUF_US = 20;
  localparam int T_BUF_CYC = T_BUF_US * CLK_MHZ;
  localparam int T_INIT_MS = 300;
  localparam int T_INIT_CYC = T_INIT_MS * 1000 * CLK_MHZ;
  localparam int T_SERIAL_MS = 300;
  localparam int T_SERIAL_CYC = T_SERIAL_MS * 1000 * CLK_MHZ;
  localparam int T_WRITE_MS = 10;
  localparam int T_WRITE_CYC = T_WRITE_MS * 1000 * CLK_MHZ;
  localparam int F_SCL_KHZ = 100;
  localparam int SCL_Q_CYC = (CLK_MHZ * 1000 + 4 * F_SCL_KHZ - 1)
    / (4 * F_SCL_KHZ);
  localparam int CNT_W = 28;
  localparam logic [6:0] DEV_ID_ADDR = 7'h50;
  localparam logic [6:0] DEV_DIAG_ADDR = 7'h51;
  localparam logic [7:0] MODULE_CONTROL_STATUS_OFS = 8'h6E;
  localparam int BIT_TX_OFF_STATE = 7;
  localparam int BIT_SOFT_TX_OFF = 6;
  localparam int BIT_SOFT_FAULT = 2;
  localparam int BIT_SOFT_LOST = 1;
  localparam int BIT_DATA_READY = 0;
endpackage

//--- omc_link_if.sv
// Pins between host board controller and optical module
interface omc_link_if;
  logic tx_off;
  logic tx_fault;
  logic receive_signal_lost;
  logic scl_host_o;
  logic scl_host_oe_n;
  logic sda_host_o;
  logic sda_host_oe_n;
  logic sda_dev_o;
  logic sda_dev_oe_n;
  logic scl;
  logic sda;
  // Open-drain wires with pull-ups
  assign scl = ~(~scl_host_oe_n & ~scl_host_o);
  assign sda = ~((~sda_host_oe_n & ~sda_host_o)
    | (~sda_dev_oe_n & ~sda_dev_o));
  modport host (
    output tx_off, scl_host_o, scl_host_oe_n, sda_host_o, sda_host_oe_n,
    input tx_fault, receive_signal_lost, scl, sda
  );
  modport dev (
    input tx_off, scl, sda,
    output tx_fault, receive_signal_lost, sda_dev_o, sda_dev_oe_n
  );
endinterface

//--- omc_module_end.sv
// Optical module end: transmit-off, fault latch, signal lost, status byte
// Behaviour
// - Transmit-off rising kills laser within 10 us
// - Transmit-off falling restores laser within 1 ms
// - Initialisation done within 300 ms, fault cleared
// - Fault output asserted within 100 us
// - Host holds transmit-off high 10 us to reset
// - Signal lost output set within 100 us
// - Signal lost output cleared within 100 us
// - Soft transmit-off set kills laser within 100 ms
// - Soft transmit-off clear restores laser in 100 ms
// - Soft fault bit set within 100 ms
// - Soft lost bit follows signal within 100 ms
// - Data-ready bit set within 1000 ms
// - Bus usable at both addresses by 300 ms
// - Host leaves 20 us idle between STOP/START
// - Write completes within 10 ms of stop
// - Host serial clock at most 100 kHz
module omc_module_end
  import omc_pkg::*;
#(
  parameter int INIT_CYC = T_INIT_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_laser_fault,
  input wire logic i_signal_present,
  output logic o_laser_en,
  omc_link_if.dev link
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_AACK = 3'h3,
    ST_RX = 3'h2,
    ST_RACK = 3'h6,
    ST_TX = 3'h7,
    ST_TACK = 3'h5
  } omc_dev_state_type;

  if (INIT_CYC < 1 || INIT_CYC >= (1 << CNT_W))
  begin : g_chk
    $error("INIT_CYC out of range");
  end

  logic [2:0] scl_sy;
  logic [2:0] sda_sy;
  logic [2:0] off_sy;
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      scl_sy <= 3'h7;
      sda_sy <= 3'h7;
      off_sy <= 3'h0;
    end
    else
    begin
      scl_sy <= {scl_sy[1:0], link.scl};
      sda_sy <= {sda_sy[1:0], link.sda};
      off_sy <= {off_sy[1:0], link.tx_off};
    end
  end

  // Only stages 1 and 2 are read; stage 0 is the metastable catcher
  logic scl_rise, scl_fall, bus_start, bus_stop, off_fall, tx_off;
  assign scl_rise = scl_sy[1] & ~scl_sy[2];
  assign scl_fall = ~scl_sy[1] & scl_sy[2];
  assign bus_start = scl_sy[1] & scl_sy[2] & sda_sy[2] & ~sda_sy[1];
  assign bus_stop = scl_sy[1] & scl_sy[2] & ~sda_sy[2] & sda_sy[1];
  assign tx_off = off_sy[1];
  assign off_fall = off_sy[2] & ~off_sy[1];

  omc_dev_state_type st_reg, st_next;
  logic [3:0] bcnt_reg, bcnt_next;
  logic [7:0] rxsh_reg, rxsh_next;
  logic [7:0] txsh_reg, txsh_next;
  logic [7:0] ptr_reg, ptr_next;
  logic first_reg, first_next;
  logic diag_reg, diag_next;
  logic rd_reg, rd_next;
  logic nack_reg, nack_next;
  logic sda_low_reg, sda_low_next;
  logic soft_off_reg, soft_off_next;
  logic fault_reg, fault_next;
  logic lost_reg, lost_next;
  logic ready_reg, ready_next;
  logic laser_reg, laser_next;
  logic [CNT_W-1:0] init_cnt_reg, init_cnt_next;
  logic [11:0] hold_reg, hold_next;
  logic [7:0] status_byte;
  logic [7:0] rd_byte;

  always_comb
  begin
    status_byte = 8'h00;
    status_byte[BIT_TX_OFF_STATE] = tx_off;
    status_byte[BIT_SOFT_TX_OFF] = soft_off_reg;
    status_byte[BIT_SOFT_FAULT] = fault_reg;
    status_byte[BIT_SOFT_LOST] = lost_reg;
    status_byte[BIT_DATA_READY] = ready_reg;
    rd_byte = (diag_reg && ptr_reg == MODULE_CONTROL_STATUS_OFS)
      ? status_byte : 8'h00;
  end

  always_comb
  begin
    st_next = st_reg;
    bcnt_next = bcnt_reg;
    rxsh_next = rxsh_reg;
    txsh_next = txsh_reg;
    ptr_next = ptr_reg;
    first_next = first_reg;
    diag_next = diag_reg;
    rd_next = rd_reg;
    nack_next = nack_reg;
    sda_low_next = sda_low_reg;
    soft_off_next = soft_off_reg;
    fault_next = fault_reg;
    init_cnt_next = init_cnt_reg;
    ready_next = ready_reg;
    hold_next = hold_reg;
    // Power-on initialisation gates the laser and the data-ready bit
    if (!ready_reg)
    begin
      if (init_cnt_reg == CNT_W'(INIT_CYC - 1))
        ready_next = 1'b1;
      else
        init_cnt_next = init_cnt_reg + 1'b1;
    end
    // Measure how long transmit-off has been high, saturating
    if (!tx_off)
      hold_next = 12'h000;
    else if (hold_reg < 12'(T_RESET_CYC))
      hold_next = hold_reg + 12'h001;
    // A short glitch on transmit-off must not unlatch a fault
    if (off_fall && hold_reg >= 12'(T_RESET_CYC))
      fault_next = 1'b0;
    // Set wins so a fault still present relatches at once
    if (i_laser_fault)
      fault_next = 1'b1;
    lost_next = ~i_signal_present;
    laser_next = ready_reg & ~tx_off & ~soft_off_reg & ~fault_reg;
    // Serial bus slave, answering at once after reset
    if (bus_stop)
    begin
      st_next = ST_IDLE;
      sda_low_next = 1'b0;
    end
    else if (bus_start)
    begin
      st_next = ST_ADDR;
      bcnt_next = 4'h0;
      sda_low_next = 1'b0;
    end
    else if (scl_rise)
    begin
      if (st_reg == ST_ADDR || st_reg == ST_RX)
      begin
        rxsh_next = {rxsh_reg[6:0], sda_sy[2]};
        bcnt_next = bcnt_reg + 4'h1;
      end
      else if (st_reg == ST_TX)
        bcnt_next = bcnt_reg + 4'h1;
      else if (st_reg == ST_TACK)
        nack_next = sda_sy[2];
    end
    else if (scl_fall)
    begin
      unique case (st_reg)
        ST_IDLE: ;
        ST_ADDR:
          if (bcnt_reg == 4'h8)
          begin
            if (rxsh_reg[7:1] == DEV_ID_ADDR
              || rxsh_reg[7:1] == DEV_DIAG_ADDR)
            begin
              st_next = ST_AACK;
              sda_low_next = 1'b1;
              rd_next = rxsh_reg[0];
              diag_next = rxsh_reg[7:1] == DEV_DIAG_ADDR;
            end
            else
              st_next = ST_IDLE;
          end
        ST_AACK:
        begin
          bcnt_next = 4'h0;
          if (rd_reg)
          begin
            st_next = ST_TX;
            txsh_next = rd_byte;
            sda_low_next = ~rd_byte[7];
          end
          else
          begin
            st_next = ST_RX;
            first_next = 1'b1;
            sda_low_next = 1'b0;
          end
        end
        ST_RX:
          if (bcnt_reg == 4'h8)
          begin
            st_next = ST_RACK;
            sda_low_next = 1'b1;
            first_next = 1'b0;
            if (first_reg)
              ptr_next = rxsh_reg;
            else
            begin
              // Committed at once, well inside the write cycle time
              if (diag_reg && ptr_reg == MODULE_CONTROL_STATUS_OFS)
                soft_off_next = rxsh_reg[BIT_SOFT_TX_OFF];
              ptr_next = ptr_reg + 8'h01;
            end
          end
        ST_RACK:
        begin
          st_next = ST_RX;
          bcnt_next = 4'h0;
          sda_low_next = 1'b0;
        end
        ST_TX:
          if (bcnt_reg == 4'h8)
          begin
            st_next = ST_TACK;
            sda_low_next = 1'b0;
            ptr_next = ptr_reg + 8'h01;
          end
          else
          begin
            txsh_next = {txsh_reg[6:0], 1'b0};
            sda_low_next = ~txsh_reg[6];
          end
        ST_TACK:
          if (nack_reg)
            st_next = ST_IDLE;
          else
          begin
            st_next = ST_TX;
            bcnt_next = 4'h0;
            txsh_next = rd_byte;
            sda_low_next = ~rd_byte[7];
          end
        default: st_next = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      st_reg <= ST_IDLE;
      bcnt_reg <= 4'h0;
      rxsh_reg <= 8'h00;
      txsh_reg <= 8'h00;
      ptr_reg <= 8'h00;
      first_reg <= 1'b0;
      diag_reg <= 1'b0;
      rd_reg <= 1'b0;
      nack_reg <= 1'b0;
      sda_low_reg <= 1'b0;
      soft_off_reg <= 1'b0;
      fault_reg <= 1'b0;
      lost_reg <= 1'b1;
      ready_reg <= 1'b0;
      laser_reg <= 1'b0;
      init_cnt_reg <= '0;
      hold_reg <= 12'h000;
    end
    else
    begin
      st_reg <= st_next;
      bcnt_reg <= bcnt_next;
      rxsh_reg <= rxsh_next;
      txsh_reg <= txsh_next;
      ptr_reg <= ptr_next;
      first_reg <= first_next;
      diag_reg <= diag_next;
      rd_reg <= rd_next;
      nack_reg <= nack_next;
      sda_low_reg <= sda_low_next;
      soft_off_reg <= soft_off_next;
      fault_reg <= fault_next;
      lost_reg <= lost_next;
      ready_reg <= ready_next;
      laser_reg <= laser_next;
      init_cnt_reg <= init_cnt_next;
      hold_reg <= hold_next;
    end
  end

  assign o_laser_en = laser_reg;
  assign link.tx_fault = fault_reg;
  assign link.receive_signal_lost = lost_reg;
  assign link.sda_dev_o = 1'b0;
  assign link.sda_dev_oe_n = ~sda_low_reg;
endmodule

//--- omc_host_end.sv
// Host board controller end: pin control and serial bus master
module omc_host_end
  import omc_pkg::*;
#(
  parameter int POWERUP_CYC = T_SERIAL_CYC,
  parameter int WRITE_CYC = T_WRITE_CYC,
  parameter int Q_CYC = SCL_Q_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_cmd_valid,
  input wire logic i_cmd_write,
  input wire logic i_cmd_diag,
  input wire logic [7:0] i_cmd_ofs,
  input wire logic [7:0] i_cmd_data,
  output logic o_cmd_ready,
  output logic o_rsp_valid,
  output logic [7:0] o_rsp_data,
  output logic o_rsp_nack,
  input wire logic i_tx_off_req,
  input wire logic i_fault_reset,
  output logic o_tx_fault,
  output logic o_receive_signal_lost,
  omc_link_if.host link
);
  typedef enum logic [1:0] {
    HS_WAIT = 2'h0,
    HS_IDLE = 2'h1,
    HS_RUN = 2'h3,
    HS_GAP = 2'h2
  } omc_host_state_type;
  typedef enum logic [1:0] {
    OP_START,
    OP_BYTE_OUT,
    OP_BYTE_IN,
    OP_STOP
  } omc_op_type;

  if (POWERUP_CYC < 1 || WRITE_CYC < T_BUF_CYC || Q_CYC < SCL_Q_CYC
    || POWERUP_CYC >= (1 << CNT_W) || WRITE_CYC >= (1 << CNT_W)
    || Q_CYC >= 4096)
  begin : g_chk
    $error("omc_host_end parameter out of range");
  end

  logic [1:0] sda_sy, flt_sy, lost_sy;
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      sda_sy <= 2'h3;
      flt_sy <= 2'h0;
      lost_sy <= 2'h3;
    end
    else
    begin
      sda_sy <= {sda_sy[0], link.sda};
      flt_sy <= {flt_sy[0], link.tx_fault};
      lost_sy <= {lost_sy[0], link.receive_signal_lost};
    end
  end

  // Fault reset pulse on the transmit-off pin
  logic [11:0] rst_cnt_reg, rst_cnt_next;
  logic tx_off_reg, tx_off_next;
  always_comb
  begin
    rst_cnt_next = rst_cnt_reg;
    if (rst_cnt_reg != 12'h000)
      rst_cnt_next = rst_cnt_reg - 12'h001;
    else if (i_fault_reset)
      rst_cnt_next = 12'(T_RESET_CYC);
    tx_off_next = i_tx_off_req | (rst_cnt_next != 12'h000);
  end
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      rst_cnt_reg <= 12'h000;
      tx_off_reg <= 1'b0;
    end
    else
    begin
      rst_cnt_reg <= rst_cnt_next;
      tx_off_reg <= tx_off_next;
    end
  end

  omc_host_state_type st_reg, st_next;
  logic [CNT_W-1:0] wcnt_reg, wcnt_next;
  logic [11:0] qcnt_reg, qcnt_next;
  logic [1:0] qph_reg, qph_next;
  logic [2:0] step_reg, step_next;
  logic [3:0] bit_reg, bit_next;
  logic [7:0] sh_reg, sh_next;
  logic [7:0] rdat_reg, rdat_next;
  logic wr_reg, wr_next, diag_reg, diag_next;
  logic [7:0] ofs_reg, ofs_next, dat_reg, dat_next;
  logic nack_reg, nack_next, scl_low_reg, scl_low_next;
  logic sda_low_reg, sda_low_next, rsp_reg, rsp_next;
  omc_op_type op;
  logic [2:0] last_step;
  logic tick;

  function automatic logic [7:0] byte_of(input logic [2:0] s,
    input logic d, input logic w, input logic [7:0] o, input logic [7:0] v);
    logic [6:0] a;
    a = d ? DEV_DIAG_ADDR : DEV_ID_ADDR;
    unique case (s)
      3'h1: byte_of = {a, 1'b0};
      3'h2: byte_of = o;
      3'h3: byte_of = w ? v : 8'h00;
      3'h4: byte_of = {a, 1'b1};
      default: byte_of = 8'h00;
    endcase
  endfunction

  always_comb
  begin
    last_step = wr_reg ? 3'h4 : 3'h6;
    if (step_reg == 3'h0 || (!wr_reg && step_reg == 3'h3))
      op = OP_START;
    else if (step_reg == last_step)
      op = OP_STOP;
    else if (!wr_reg && step_reg == 3'h5)
      op = OP_BYTE_IN;
    else
      op = OP_BYTE_OUT;
    tick = qcnt_reg == 12'(Q_CYC - 1);
  end

  always_comb
  begin
    st_next = st_reg;
    wcnt_next = wcnt_reg;
    qcnt_next = 12'h000;
    qph_next = qph_reg;
    step_next = step_reg;
    bit_next = bit_reg;
    sh_next = sh_reg;
    rdat_next = rdat_reg;
    wr_next = wr_reg;
    diag_next = diag_reg;
    ofs_next = ofs_reg;
    dat_next = dat_reg;
    nack_next = nack_reg;
    scl_low_next = scl_low_reg;
    sda_low_next = sda_low_reg;
    rsp_next = 1'b0;
    unique case (st_reg)
      HS_WAIT, HS_GAP:
        if (wcnt_reg == '0)
          st_next = HS_IDLE;
        else
          wcnt_next = wcnt_reg - 1'b1;
      HS_IDLE:
        if (i_cmd_valid)
        begin
          st_next = HS_RUN;
          wr_next = i_cmd_write;
          diag_next = i_cmd_diag;
          ofs_next = i_cmd_ofs;
          dat_next = i_cmd_data;
          step_next = 3'h0;
          bit_next = 4'h0;
          qph_next = 2'h0;
          nack_next = 1'b0;
        end
      HS_RUN:
      begin
        // Quarter-period pacing keeps the serial clock at its limit
        qcnt_next = tick ? 12'h000 : qcnt_reg + 12'h001;
        if (tick)
        begin
          qph_next = qph_reg + 2'h1;
          unique case (qph_reg)
            2'h0:
              if (op == OP_START)
                sda_low_next = 1'b0;
              else if (op == OP_STOP)
                sda_low_next = 1'b1;
              else
                sda_low_next = op == OP_BYTE_OUT && bit_reg != 4'h8
                  && !sh_reg[7];
            2'h1: scl_low_next = 1'b0;
            2'h2:
              if (op == OP_START)
                sda_low_next = 1'b1;
              else if (op == OP_STOP)
                sda_low_next = 1'b0;
              else if (bit_reg != 4'h8)
              begin
                rdat_next = {rdat_reg[6:0], sda_sy[1]};
                sh_next = {sh_reg[6:0], 1'b0};
              end
              else if (op == OP_BYTE_OUT)
                nack_next = nack_reg | sda_sy[1];
            2'h3:
            begin
              if (op != OP_STOP)
                scl_low_next = 1'b1;
              if ((op == OP_BYTE_OUT || op == OP_BYTE_IN)
                && bit_reg != 4'h8)
                bit_next = bit_reg + 4'h1;
              else if (op == OP_STOP)
              begin
                st_next = HS_GAP;
                rsp_next = 1'b1;
                wcnt_next = wr_reg ? CNT_W'(WRITE_CYC)
                  : CNT_W'(T_BUF_CYC);
              end
              else
              begin
                bit_next = 4'h0;
                // A refused byte skips straight to the stop
                step_next = (op == OP_BYTE_OUT && (nack_reg
                  || sda_sy[1])) ? last_step : step_reg + 3'h1;
                sh_next = byte_of(step_reg + 3'h1, diag_reg, wr_reg,
                  ofs_reg, dat_reg);
              end
            end
            default: ;
          endcase
        end
      end
      default: st_next = HS_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      st_reg <= HS_WAIT;
      wcnt_reg <= CNT_W'(POWERUP_CYC);
      qcnt_reg <= 12'h000;
      qph_reg <= 2'h0;
      step_reg <= 3'h0;
      bit_reg <= 4'h0;
      sh_reg <= 8'h00;
      rdat_reg <= 8'h00;
      wr_reg <= 1'b0;
      diag_reg <= 1'b0;
      ofs_reg <= 8'h00;
      dat_reg <= 8'h00;
      nack_reg <= 1'b0;
      scl_low_reg <= 1'b0;
      sda_low_reg <= 1'b0;
      rsp_reg <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
      wcnt_reg <= wcnt_next;
      qcnt_reg <= qcnt_next;
      qph_reg <= qph_next;
      step_reg <= step_next;
      bit_reg <= bit_next;
      sh_reg <= sh_next;
      rdat_reg <= rdat_next;
      wr_reg <= wr_next;
      diag_reg <= diag_next;
      ofs_reg <= ofs_next;
      dat_reg <= dat_next;
      nack_reg <= nack_next;
      scl_low_reg <= scl_low_next;
      sda_low_reg <= sda_low_next;
      rsp_reg <= rsp_next;
    end
  end

  assign o_cmd_ready = st_reg == HS_IDLE;
  assign o_rsp_valid = rsp_reg;
  assign o_rsp_data = rdat_reg;
  assign o_rsp_nack = nack_reg;
  assign o_tx_fault = flt_sy[1];
  assign o_receive_signal_lost = lost_sy[1];
  assign link.tx_off = tx_off_reg;
  assign link.scl_host_o = 1'b0;
  assign link.scl_host_oe_n = ~scl_low_reg;
  assign link.sda_host_o = 1'b0;
  assign link.sda_host_oe_n = ~sda_low_reg;
endmodule

//--- omc_link_sva.sv
// Checker on the pins between host end and module end
module omc_link_sva
  import omc_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_laser_fault,
  input wire logic i_signal_present,
  input wire logic o_laser_en,
  input wire logic tx_off,
  input wire logic tx_fault,
  input wire logic receive_signal_lost,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_dev_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CAP = 100000;
  logic scl_reg;
  logic sda_reg;
  logic off_reg;
  int idle_reg;
  int rise_reg;
  int hi_reg;
  int run_reg;
  int since_reg;
  logic stop_seen;
  logic rise_seen;
  assign stop_seen = scl && scl_reg && sda && !sda_reg;
  assign rise_seen = scl && !scl_reg;
  // Saturating counters so a quiet bus never wraps into a false alarm
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
      off_reg <= 1'b0;
      idle_reg <= CAP;
      rise_reg <= CAP;
      hi_reg <= 0;
      run_reg <= 0;
      since_reg <= 255;
    end
    else
    begin
      scl_reg <= scl;
      sda_reg <= sda;
      off_reg <= tx_off;
      idle_reg <= stop_seen ? 1 : (idle_reg < CAP ? idle_reg + 1 : CAP);
      rise_reg <= rise_seen ? 1 : (rise_reg < CAP ? rise_reg + 1 : CAP);
      hi_reg <= tx_off ? (hi_reg < CAP ? hi_reg + 1 : CAP) : 0;
      run_reg <= (off_reg && !tx_off) ? hi_reg : run_reg;
      since_reg <= tx_off ? 0 : (since_reg < 255 ? since_reg + 1 : 255);
    end
  end
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_resetn);
  laser_off_a: assert property (tx_off [*8] |-> !o_laser_en)
    else $error("laser on while transmit-off held");
  fault_set_a: assert property (i_laser_fault |-> ##[1:4] tx_fault)
    else $error("fault output late");
  fault_clear_a: assert property ($fell(tx_fault) |->
    since_reg <= 8 && run_reg >= T_RESET_CYC)
    else $error("fault cleared without a long transmit-off pulse");
  fault_laser_a: assert property (tx_fault [*4] |-> !o_laser_en)
    else $error("laser on while fault latched");
  lost_follow_a: assert property ($changed(i_signal_present) |->
    ##[1:4] (receive_signal_lost == !i_signal_present))
    else $error("signal lost output does not follow input");
  sda_edge_a: assert property ($changed(sda_dev_oe_n) |-> !scl)
    else $error("module data line moved while clock high");
  bus_free_a: assert property ((scl && scl_reg && sda_reg && !sda)
    |-> idle_reg >= T_BUF_CYC)
    else $error("start too soon after stop");
  scl_rate_a: assert property (rise_seen
    |-> rise_reg >= 4 * SCL_Q_CYC)
    else $error("serial clock too fast");
endmodule

//--- optical_module_ctrl_status_tb.sv
// Self-checking bench joining host end and module end
module optical_module_ctrl_status_tb
  import omc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk_sys = 1'b0;
  logic i_resetn = 1'b0;
  logic i_laser_fault = 1'b0;
  logic i_signal_present = 1'b1;
  logic i_cmd_valid = 1'b0;
  logic i_cmd_write = 1'b0;
  logic i_cmd_diag = 1'b0;
  logic [7:0] i_cmd_ofs = 8'h00;
  logic [7:0] i_cmd_data = 8'h00;
  logic i_tx_off_req = 1'b0;
  logic i_fault_reset = 1'b0;
  logic o_laser_en;
  logic o_cmd_ready;
  logic o_rsp_valid;
  logic [7:0] o_rsp_data;
  logic o_rsp_nack;
  logic o_tx_fault;
  logic o_receive_signal_lost;
  int errors = 0;
  int cmp_count = 0;
  always #2.5 i_clk_sys = ~i_clk_sys;
  omc_link_if link ();
  omc_module_end #(.INIT_CYC(50)) u_omc_module_end (
    .i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
    .i_laser_fault(i_laser_fault), .i_signal_present(i_signal_present),
    .o_laser_en(o_laser_en), .link(link));
  omc_host_end #(.POWERUP_CYC(20), .WRITE_CYC(4000)) u_omc_host_end (
    .i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
    .i_cmd_valid(i_cmd_valid), .i_cmd_write(i_cmd_write),
    .i_cmd_diag(i_cmd_diag), .i_cmd_ofs(i_cmd_ofs),
    .i_cmd_data(i_cmd_data), .o_cmd_ready(o_cmd_ready),
    .o_rsp_valid(o_rsp_valid), .o_rsp_data(o_rsp_data),
    .o_rsp_nack(o_rsp_nack), .i_tx_off_req(i_tx_off_req),
    .i_fault_reset(i_fault_reset), .o_tx_fault(o_tx_fault),
    .o_receive_signal_lost(o_receive_signal_lost), .link(link));
  omc_link_sva u_omc_link_sva (
    .i_clk_sys(i_clk_sys), .i_resetn(i_resetn),
    .i_laser_fault(i_laser_fault), .i_signal_present(i_signal_present),
    .o_laser_en(o_laser_en), .tx_off(link.tx_off),
    .tx_fault(link.tx_fault),
    .receive_signal_lost(link.receive_signal_lost),
    .scl(link.scl), .sda(link.sda), .sda_dev_oe_n(link.sda_dev_oe_n));
  task automatic tally_and_finish();
    if (errors == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic pick(input int sel);
    case (sel)
      0: return o_laser_en;
      1: return o_tx_fault;
      2: return o_receive_signal_lost;
      3: return o_cmd_ready;
      default: return o_rsp_valid;
    endcase
  endfunction
  // Sampled 1 ns after the edge so registered outputs have settled
  task automatic wait_val(input int sel, input logic v, input int lim);
    repeat (lim)
    begin
      @(posedge i_clk_sys);
      #1;
      if (pick(sel) === v)
      begin
        check(8'(pick(sel)), 8'(v));
        return;
      end
    end
    check(8'(pick(sel)), 8'(v));
    tally_and_finish();
  endtask
  // One byte at the status place of the diagnostic address
  task automatic cmd(input logic w, input logic [7:0] d);
    wait_val(3, 1'b1, 10000);
    @(posedge i_clk_sys);
    i_cmd_valid <= 1'b1;
    i_cmd_write <= w;
    i_cmd_diag <= 1'b1;
    i_cmd_ofs <= MODULE_CONTROL_STATUS_OFS;
    i_cmd_data <= d;
    @(posedge i_clk_sys);
    i_cmd_valid <= 1'b0;
    wait_val(4, 1'b1, 90000);
    check(8'(o_rsp_nack), 8'h00);
  endtask
  task automatic start_up();
    wait_val(0, 1'b1, 100);
    check(8'(o_tx_fault), 8'h00);
    wait_val(3, 1'b1, 100);
  endtask
  task automatic pin_off_on();
    @(posedge i_clk_sys);
    i_tx_off_req <= 1'b1;
    wait_val(0, 1'b0, 2000);
    @(posedge i_clk_sys);
    i_tx_off_req <= 1'b0;
    wait_val(0, 1'b1, 200000);
  endtask
  task automatic fault_latch();
    @(posedge i_clk_sys);
    i_laser_fault <= 1'b1;
    @(posedge i_clk_sys);
    i_laser_fault <= 1'b0;
    wait_val(1, 1'b1, 20000);
    wait_val(0, 1'b0, 10);
    repeat (3000) @(posedge i_clk_sys);
    i_tx_off_req <= 1'b1;
    repeat (100) @(posedge i_clk_sys);
    i_tx_off_req <= 1'b0;
    repeat (50) @(posedge i_clk_sys);
    #1;
    check(8'(o_tx_fault), 8'h01);
    check(8'(o_laser_en), 8'h00);
    @(posedge i_clk_sys);
    i_fault_reset <= 1'b1;
    @(posedge i_clk_sys);
    i_fault_reset <= 1'b0;
    wait_val(1, 1'b0, 3000);
    wait_val(0, 1'b1, 200000);
  endtask
  task automatic signal_loss();
    @(posedge i_clk_sys);
    i_signal_present <= 1'b0;
    wait_val(2, 1'b1, 20000);
    @(posedge i_clk_sys);
    i_signal_present <= 1'b1;
    wait_val(2, 1'b0, 20000);
  endtask
  task automatic soft_off();
    cmd(1'b1, 8'h40);
    wait_val(0, 1'b0, 400);
    wait_val(3, 1'b1, 5000);
  endtask
  // Fault cleared first, so only the soft bit still holds the laser off
  task automatic soft_on();
    @(posedge i_clk_sys);
    i_fault_reset <= 1'b1;
    @(posedge i_clk_sys);
    i_fault_reset <= 1'b0;
    wait_val(1, 1'b0, 3000);
    check(8'(o_laser_en), 8'h00);
    cmd(1'b1, 8'h00);
    wait_val(0, 1'b1, 400);
  endtask
  // Ready, lost, fault and soft-off bits all set: expect 0x47
  task automatic status_read();
    @(posedge i_clk_sys);
    i_laser_fault <= 1'b1;
    i_signal_present <= 1'b0;
    @(posedge i_clk_sys);
    i_laser_fault <= 1'b0;
    repeat (20) @(posedge i_clk_sys);
    cmd(1'b0, 8'h00);
    check(o_rsp_data, 8'h47);
  endtask
  initial
  begin
    repeat (16) @(posedge i_clk_sys);
    i_resetn <= 1'b1;
    start_up();
    pin_off_on();
    fault_latch();
    signal_loss();
    soft_off();
    status_read();
    soft_on();
    tally_and_finish();
  end
endmodule
